// *** pkg/wprot_pkg.sv ***
// Constants and types shared by the block write-protect controller
package wprot_pkg;

  // ************************************************************
  // Bus and device addressing
  // ************************************************************
  localparam logic [7:0] DEFAULT_DEV_ADDR   = 8'hae;
  localparam logic [7:0] NULL_DEV_ADDR      = 8'h00;

  // ************************************************************
  // Command byte fields, bit 7 is the most significant data bit
  // ************************************************************
  localparam int         CMD_DISARM_POS     = 7;
  localparam int         CMD_ARM_POS        = 6;
  localparam int         CMD_PON_POS        = 5;
  localparam int         CMD_PROTECT_OFF_CMD_POS       = 4;

  // ************************************************************
  // Status byte fields and fixed answers
  // ************************************************************
  localparam int         STAT_PON_POS       = 5;
  localparam int         STAT_PWF_POS       = 4;
  localparam int         STAT_EX_POS        = 2;
  localparam logic [7:0] STATUS_CLEAR       = 8'h00;
  localparam logic [7:0] ACK_STATUS_NORMAL  = 8'h20;
  localparam logic [7:0] ACK_STATUS_IDLE    = 8'h04;

  // ************************************************************
  // Mask store geometry
  // ************************************************************
  localparam int         MASK_BYTES         = 8;
  localparam int         MASK_BITS          = 64;
  localparam int         SEQ_W              = 3;
  localparam logic [2:0] SEQ_FIRST          = 3'h0;
  localparam logic [2:0] SEQ_STEP           = 3'h1;
  localparam logic [63:0] MASK_RESET        = 64'h0;
  localparam int         BLK_IDX_W          = 6;
  localparam int         MEM_ADDR_W         = 16;

  // ************************************************************
  // Block size strap and address bit positions
  // ************************************************************
  typedef enum logic [1:0] {
    BLK_512  = 2'h0,
    BLK_1K   = 2'h1,
    BLK_2K   = 2'h2
  } blk_size_t;
  localparam int         IDX_LSB_512        = 9;
  localparam int         IDX_LSB_1K         = 10;
  localparam int         IDX_LSB_2K         = 11;

endpackage

// *** rtl/mask_store.sv ***
// 64-bit protect mask with its byte-wide load sequencer
`timescale 1ns/1ps
module mask_store
  import wprot_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Load controls
  input  wire logic                  seq_clear_in,
  input  wire logic                  load_in,
  input  wire logic [7:0]            data_in,
  // Mask contents
  output logic      [MASK_BITS-1:0]  mask_out,
  output logic      [SEQ_W-1:0]      seq_out
);

  logic [MASK_BITS-1:0] mask_reg;
  logic [SEQ_W-1:0]     seq_reg;

  // Sequencer: restarts on command, steps per byte, wraps after eight
  always_ff @(posedge clk_in) begin
    if (rst_in || seq_clear_in) begin
      seq_reg <= SEQ_FIRST;
    end else if (load_in) begin
      seq_reg <= seq_reg + SEQ_STEP;
    end
  end

  // Byte k of the mask holds blocks 8k through 8k+7, bit 0 in data MSB
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_reg <= MASK_RESET;
    end else if (load_in && !seq_clear_in) begin
      for (int b = 0; b < 8; b++) begin
        mask_reg[{seq_reg, b[2:0]}] <= data_in[7 - b];
      end
    end
  end

  assign mask_out = mask_reg;
  assign seq_out  = seq_reg;

endmodule

// *** rtl/block_lookup.sv ***
// Maps a memory address to its block and looks up the protect bit
`timescale 1ns/1ps
module block_lookup
  import wprot_pkg::*;
(
  // Address and geometry
  input  wire logic [MEM_ADDR_W-1:0] addr_in,
  input  wire blk_size_t             size_in,
  input  wire logic [MASK_BITS-1:0]  mask_in,
  // Result
  output logic      [BLK_IDX_W-1:0]  block_out,
  output logic                       protected_out
);

  // Address bits that index the mask, per strap setting
  always_comb begin
    case (size_in)
      BLK_1K:  block_out = addr_in[IDX_LSB_1K +: BLK_IDX_W];
      BLK_2K:  block_out = {1'b0, addr_in[IDX_LSB_2K +: BLK_IDX_W-1]};
      default: block_out = {1'b0, addr_in[IDX_LSB_512 +: BLK_IDX_W-1]};
    endcase
  end

  // A one in the mask protects the block
  assign protected_out = mask_in[block_out];

endmodule

// *** rtl/block_write_protect_controller.sv ***
// Block write-protect controller: command, mask load, status and interrupt
//
// How it works
// - Acknowledge with interrupt pending clears it, returns device address and status.
// - Acknowledge with nothing pending returns address zero and status 04.
// - Every command byte restarts the mask sequencer at blocks 0 to 7.
// - A mask bit of one protects its block; zero leaves it writable.
// - Sequencer steps one byte per data write and wraps after eight.
// - With 2048-byte blocks only bytes 0 to 3 matter; 4 to 7 still stored.
// - One command byte may enable protection and arm or disarm together.
// - Armed violations request interrupts; disarmed ones are dropped, never queued.
// - Acknowledge clears pending interrupt and all status except protect-on.
// - Normal acknowledge status byte is 20.
// - Power events or initialize switch disarm, clear status, sequencer and protection.
// - Responds at device address AE unless strapped to another address.
// - Mask byte k bit 7-b governs block 8k+b at (8k+b) times block size; with 512-byte blocks only blocks 0 to 31 exist.
// - With 512-byte blocks the lowest 16K pattern repeats in each higher 16K.
// - Protected write becomes a read, interrupts and sets write-fault status.
// - Any command clears status except protect-on, which follows enable.
`timescale 1ns/1ps
module block_write_protect_controller
  import wprot_pkg::*;
(
  // Clock and power-up reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  // Panel and power pins (asynchronous)
  input  wire logic                  init_switch_in,
  input  wire logic                  power_fail_in,
  // Straps (asynchronous, static)
  input  wire logic                  addr_strap_en_in,
  input  wire logic [7:0]            addr_strap_in,
  input  wire logic [1:0]            blk_size_strap_in,
  // Processor I/O bus, same clock
  input  wire logic [7:0]            bus_addr_in,
  input  wire logic [7:0]            bus_data_in,
  input  wire logic                  output_command_instr_in,
  input  wire logic                  data_write_in,
  input  wire logic                  status_req_in,
  input  wire logic                  interrupt_ack_instr_in,
  // Processor memory cycle, same clock
  input  wire logic [MEM_ADDR_W-1:0] mem_addr_in,
  input  wire logic                  mem_write_in,
  input  wire logic                  privileged_in,
  // Status read answer
  output logic      [7:0]            status_out,
  output logic                       status_valid_out,
  // Interrupt acknowledge answer
  output logic      [7:0]            ack_addr_out,
  output logic      [7:0]            ack_status_out,
  output logic                       ack_valid_out,
  // Interrupt and protection outputs
  output logic                       irq_out,
  output logic                       write_inhibit_out,
  output logic                       protect_on_out,
  output logic                       armed_out,
  output logic      [7:0]            dev_addr_out
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic       init_meta_reg;
  logic       init_sync_reg;
  logic       pfail_meta_reg;
  logic       pfail_sync_reg;
  logic       strap_en_meta_reg;
  logic       strap_en_sync_reg;
  logic [7:0] strap_addr_meta_reg;
  logic [7:0] strap_addr_sync_reg;
  logic [1:0] size_meta_reg;
  logic [1:0] size_sync_reg;

  // Two flops on every panel, power and strap pin before any logic looks at it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      init_meta_reg       <= 1'b0;
      init_sync_reg       <= 1'b0;
      pfail_meta_reg      <= 1'b0;
      pfail_sync_reg      <= 1'b0;
      strap_en_meta_reg   <= 1'b0;
      strap_en_sync_reg   <= 1'b0;
      strap_addr_meta_reg <= NULL_DEV_ADDR;
      strap_addr_sync_reg <= NULL_DEV_ADDR;
      size_meta_reg       <= BLK_512;
      size_sync_reg       <= BLK_512;
    end else begin
      init_meta_reg       <= init_switch_in;
      init_sync_reg       <= init_meta_reg;
      pfail_meta_reg      <= power_fail_in;
      pfail_sync_reg      <= pfail_meta_reg;
      strap_en_meta_reg   <= addr_strap_en_in;
      strap_en_sync_reg   <= strap_en_meta_reg;
      strap_addr_meta_reg <= addr_strap_in;
      strap_addr_sync_reg <= strap_addr_meta_reg;
      size_meta_reg       <= blk_size_strap_in;
      size_sync_reg       <= size_meta_reg;
    end
  end

  // ************************************************************
  // Initialisation and addressing
  // ************************************************************
  logic       init_clear;
  logic [7:0] dev_addr;
  logic [7:0] dev_addr_reg;
  logic       addr_hit;
  blk_size_t  blk_size;

  // Power-up, power-down and panel initialize all clear the controller
  assign init_clear = rst_in || init_sync_reg || pfail_sync_reg;

  // Device address register: default unless the straps override it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dev_addr_reg <= DEFAULT_DEV_ADDR;
    end else if (strap_en_sync_reg) begin
      dev_addr_reg <= strap_addr_sync_reg;
    end else begin
      dev_addr_reg <= DEFAULT_DEV_ADDR;
    end
  end

  // Address match against the registered device address
  assign dev_addr = dev_addr_reg;
  assign addr_hit = (bus_addr_in == dev_addr);

  // Unused strap code falls back to the smallest block size
  always_comb begin
    case (size_sync_reg)
      BLK_1K:  blk_size = BLK_1K;
      BLK_2K:  blk_size = BLK_2K;
      default: blk_size = BLK_512;
    endcase
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic cmd_hit;
  logic data_hit;
  logic stat_hit;
  logic ack_take;
  logic cmd_disarm;
  logic cmd_arm;
  logic cmd_pon;
  logic cmd_protect_off_cmd;

  // Addressed strobes; acknowledge is broadcast on the bus
  assign cmd_hit  = output_command_instr_in && addr_hit;
  assign data_hit = data_write_in && addr_hit;
  assign stat_hit = status_req_in && addr_hit;
  assign ack_take = interrupt_ack_instr_in;

  // Command byte fields, all acted on together
  assign cmd_disarm = cmd_hit && bus_data_in[CMD_DISARM_POS];
  assign cmd_arm    = cmd_hit && bus_data_in[CMD_ARM_POS];
  assign cmd_pon    = cmd_hit && bus_data_in[CMD_PON_POS];
  assign cmd_protect_off_cmd   = cmd_hit && bus_data_in[CMD_PROTECT_OFF_CMD_POS];

  // ************************************************************
  // Mask store and block lookup
  // ************************************************************
  logic [MASK_BITS-1:0] mask;
  logic [BLK_IDX_W-1:0] block_idx;
  logic                 block_prot;

  mask_store u_mask (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .seq_clear_in (init_clear || cmd_hit),
    .load_in      (data_hit),
    .data_in      (bus_data_in),
    .mask_out     (mask),
    .seq_out      ()
  );

  block_lookup u_lookup (
    .addr_in       (mem_addr_in),
    .size_in       (blk_size),
    .mask_in       (mask),
    .block_out     (block_idx),
    .protected_out (block_prot)
  );

  // ************************************************************
  // Protection and arming state
  // ************************************************************
  logic protect_on_reg;
  logic armed_reg;
  logic violation;

  // Enable and disable; disable wins when both are set
  always_ff @(posedge clk_in) begin
    if (init_clear) begin
      protect_on_reg <= 1'b0;
    end else if (cmd_protect_off_cmd) begin
      protect_on_reg <= 1'b0;
    end else if (cmd_pon) begin
      protect_on_reg <= 1'b1;
    end
  end

  // Arm and disarm; disarm taken if both are set
  always_ff @(posedge clk_in) begin
    if (init_clear) begin
      armed_reg <= 1'b0;
    end else if (cmd_disarm) begin
      armed_reg <= 1'b0;
    end else if (cmd_arm) begin
      armed_reg <= 1'b1;
    end
  end

  // Non-privileged write into a protected block while enabled
  assign violation = protect_on_reg && mem_write_in && !privileged_in
                     && block_prot;

  // Protected write is turned into a read
  assign write_inhibit_out = violation;

  // ************************************************************
  // Status and interrupt
  // ************************************************************
  logic pwf_reg;
  logic ex_reg;
  logic pending_reg;
  logic status_clear;

  // Commands and acknowledges clear status other than protect-on
  assign status_clear = cmd_hit || ack_take;

  // Write-fault and examine: set wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (init_clear) begin
      pwf_reg <= 1'b0;
      ex_reg  <= 1'b0;
    end else if (violation) begin
      pwf_reg <= 1'b1;
      ex_reg  <= 1'b1;
    end else if (status_clear) begin
      pwf_reg <= 1'b0;
      ex_reg  <= 1'b0;
    end
  end

  // Interrupt request only when armed; dropped when disarmed
  always_ff @(posedge clk_in) begin
    if (init_clear) begin
      pending_reg <= 1'b0;
    end else if (violation && armed_reg) begin
      pending_reg <= 1'b1;
    end else if (ack_take || (cmd_disarm && !cmd_arm)) begin
      pending_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Bus answers
  // ************************************************************
  logic [7:0] status_byte;

  // Live status byte; protect-on follows the enable
  always_comb begin
    status_byte               = STATUS_CLEAR;
    status_byte[STAT_PON_POS] = protect_on_reg;
    status_byte[STAT_PWF_POS] = pwf_reg;
    status_byte[STAT_EX_POS]  = ex_reg;
  end

  // Sense status answer, one cycle after the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_out       <= STATUS_CLEAR;
      status_valid_out <= 1'b0;
    end else begin
      status_valid_out <= stat_hit;
      if (stat_hit) begin
        status_out <= status_byte;
      end
    end
  end

  // Acknowledge answer: device address and status, or the idle pair
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_addr_out   <= NULL_DEV_ADDR;
      ack_status_out <= STATUS_CLEAR;
      ack_valid_out  <= 1'b0;
    end else begin
      ack_valid_out <= ack_take;
      if (ack_take && pending_reg) begin
        ack_addr_out   <= dev_addr;
        ack_status_out <= ACK_STATUS_NORMAL;
      end else if (ack_take) begin
        ack_addr_out   <= NULL_DEV_ADDR;
        ack_status_out <= ACK_STATUS_IDLE;
      end
    end
  end

  // ************************************************************
  // Level outputs
  // ************************************************************
  assign irq_out        = pending_reg;
  assign protect_on_out = protect_on_reg;
  assign armed_out      = armed_reg;
  assign dev_addr_out   = dev_addr;

endmodule

// *** verification/wprot_asserts.sv ***
// Concurrent checks on the write-protect controller ports
`timescale 1ns/1ps
module wprot_asserts
  import wprot_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Observed inputs
  input  wire logic [7:0] bus_addr_in,
  input  wire logic [7:0] bus_data_in,
  input  wire logic       output_command_instr_in,
  input  wire logic       status_req_in,
  input  wire logic       interrupt_ack_instr_in,
  input  wire logic       mem_write_in,
  input  wire logic       privileged_in,
  // Observed outputs
  input  wire logic [7:0] status_out,
  input  wire logic       status_valid_out,
  input  wire logic [7:0] ack_addr_out,
  input  wire logic [7:0] ack_status_out,
  input  wire logic       ack_valid_out,
  input  wire logic       irq_out,
  input  wire logic       write_inhibit_out,
  input  wire logic       protect_on_out,
  input  wire logic       armed_out,
  input  wire logic [7:0] dev_addr_out
);
  // ************************************************************
  // Named steps and properties
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence cmd_s;
    output_command_instr_in && bus_addr_in == dev_addr_out;
  endsequence
  sequence fault_s;
    write_inhibit_out && armed_out;
  endsequence
  sequence ack_s;
    interrupt_ack_instr_in && !(write_inhibit_out && armed_out) && irq_out;
  endsequence
  sequence idle_ack_s;
    interrupt_ack_instr_in && !(write_inhibit_out && armed_out) && !irq_out;
  endsequence
  inhibit_cause_a: assert property (write_inhibit_out |->
    protect_on_out && mem_write_in && !privileged_in) else $error("inhibit without cause");
  fault_irq_a: assert property (fault_s |=> irq_out)
    else $error("armed fault gave no interrupt");
  irq_source_a: assert property ($rose(irq_out) |->
    $past(armed_out) && $past(write_inhibit_out)) else $error("interrupt without armed fault");
  cmd_enable_a: assert property (cmd_s |=> protect_on_out ==
    ($past(bus_data_in[CMD_PROTECT_OFF_CMD_POS]) ? 1'b0 : $past(bus_data_in[CMD_PON_POS]) ? 1'b1 :
    $past(protect_on_out))) else $error("protect enable wrong after command");
  cmd_arm_a: assert property (cmd_s |=> armed_out ==
    ($past(bus_data_in[CMD_DISARM_POS]) ? 1'b0 : $past(bus_data_in[CMD_ARM_POS]) ? 1'b1 :
    $past(armed_out))) else $error("arm state wrong after command");
  foreign_cmd_a: assert property (output_command_instr_in && bus_addr_in != dev_addr_out
    |=> $stable(protect_on_out) && $stable(armed_out)) else $error("foreign command taken");
  status_byte_a: assert property (status_req_in && bus_addr_in == dev_addr_out |=>
    status_valid_out && status_out[STAT_PON_POS] == $past(protect_on_out) &&
    status_out[STAT_PWF_POS] == status_out[STAT_EX_POS]) else $error("status answer wrong");
  ack_normal_a: assert property (ack_s |=> ack_valid_out && !irq_out &&
    ack_status_out == 8'h20 && ack_addr_out == $past(dev_addr_out)) else $error("ack answer wrong");
  ack_idle_a: assert property (idle_ack_s |=> ack_valid_out &&
    ack_addr_out == 8'h00 && ack_status_out == 8'h04) else $error("idle ack answer wrong");
  reset_state_a: assert property ($fell(rst_in) |->
    !irq_out && !armed_out && !protect_on_out) else $error("state not cleared by reset");
endmodule

bind block_write_protect_controller wprot_asserts chk (
  .clk_in(clk_in), .rst_in(rst_in), .bus_addr_in(bus_addr_in), .bus_data_in(bus_data_in),
  .output_command_instr_in(output_command_instr_in), .status_req_in(status_req_in),
  .interrupt_ack_instr_in(interrupt_ack_instr_in), .mem_write_in(mem_write_in),
  .privileged_in(privileged_in), .status_out(status_out), .status_valid_out(status_valid_out),
  .ack_addr_out(ack_addr_out), .ack_status_out(ack_status_out), .ack_valid_out(ack_valid_out),
  .irq_out(irq_out), .write_inhibit_out(write_inhibit_out), .protect_on_out(protect_on_out),
  .armed_out(armed_out), .dev_addr_out(dev_addr_out));

// *** verification/cpu_model.sv ***
// Processor-side model driving the I/O bus and memory cycles
`timescale 1ns/1ps
module cpu_model
  import wprot_pkg::*;
(
  // Clock
  input  wire logic                  clk_in,
  // I/O bus
  output logic      [7:0]            addr_out,
  output logic      [7:0]            data_out,
  output logic                       cmd_out,
  output logic                       wr_out,
  output logic                       sr_out,
  output logic                       ack_out,
  // Memory cycle
  output logic      [MEM_ADDR_W-1:0] mem_addr_out,
  output logic                       mem_wr_out,
  output logic                       priv_out
);
  // Quiet bus at time zero
  initial begin
    {addr_out, data_out, cmd_out, wr_out, sr_out, ack_out} = '0;
    {mem_addr_out, mem_wr_out, priv_out} = '0;
  end
  // One transfer: 0 command, 1 data, 2 status, 3 acknowledge
  task automatic io(input int k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    cmd_out  <= (k == 0);
    wr_out   <= (k == 1);
    sr_out   <= (k == 2);
    ack_out  <= (k == 3);
    @(posedge clk_in);
    {cmd_out, wr_out, sr_out, ack_out} <= 4'h0;
    addr_out <= ~a; // Released bus never shows a stale value
    data_out <= ~d;
  endtask
  // One memory cycle; p high while the status word leaves writes privileged
  task automatic mem(input logic [15:0] a, input logic w, input logic p);
    @(posedge clk_in);
    mem_addr_out <= a;
    mem_wr_out   <= w;
    priv_out     <= p;
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the block write-protect controller
`timescale 1ns/1ps
module tb;
  import wprot_pkg::*;
  // ************************************************************
  // Wiring, helpers and checks
  // ************************************************************
  logic        clk_in, rst_in, init_sw, pwr_fail, strap_en;
  logic [7:0]  strap_addr, b_addr, b_data, st, ack_a, ack_s, dev_a, dev_exp;
  logic [1:0]  size;
  logic [15:0] m_addr;
  logic        oc, dw, sr, ai, m_wr, priv, st_v, ack_v, irq, inh, protect_on, arm;
  logic [7:0]  mask [8];
  int          failures, num_checks;

  cpu_model cpu (.clk_in(clk_in), .addr_out(b_addr), .data_out(b_data), .cmd_out(oc),
    .wr_out(dw), .sr_out(sr), .ack_out(ai), .mem_addr_out(m_addr), .mem_wr_out(m_wr),
    .priv_out(priv));
  block_write_protect_controller dut (.clk_in(clk_in), .rst_in(rst_in),
    .init_switch_in(init_sw), .power_fail_in(pwr_fail), .addr_strap_en_in(strap_en),
    .addr_strap_in(strap_addr), .blk_size_strap_in(size), .bus_addr_in(b_addr),
    .bus_data_in(b_data), .output_command_instr_in(oc), .data_write_in(dw),
    .status_req_in(sr), .interrupt_ack_instr_in(ai), .mem_addr_in(m_addr),
    .mem_write_in(m_wr), .privileged_in(priv), .status_out(st), .status_valid_out(st_v),
    .ack_addr_out(ack_a), .ack_status_out(ack_s), .ack_valid_out(ack_v), .irq_out(irq),
    .write_inhibit_out(inh), .protect_on_out(protect_on), .armed_out(arm), .dev_addr_out(dev_a));

  // Expected protect bit for an address at a block size
  function automatic logic exp_prot(input logic [15:0] a, input logic [1:0] s);
    logic [5:0] i;
    i = (s == 2'h1) ? a[15:10] : (s == 2'h2) ? {1'b0, a[15:11]} : {1'b0, a[13:9]};
    return mask[i[5:3]][3'h7 - i[2:0]];
  endfunction
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmd(input logic [7:0] d);
    cpu.io(0, dev_exp, d);
    #1;
  endtask
  // Bounded wait for a registered answer
  task automatic answer(input logic want_ack);
    #1;
    for (int n = 0; n < 3; n++) begin
      if ((want_ack ? ack_v : st_v) === 1'b1) break;
      @(posedge clk_in);
      #1;
    end
  endtask
  task automatic status_is(input logic [7:0] e);
    cpu.io(2, dev_exp, 8'h00);
    answer(1'b0);
    chk(st_v === 1'b1 && st === e, "status byte");
  endtask
  task automatic ack_is(input logic [7:0] ea, input logic [7:0] es);
    cpu.io(3, 8'h00, 8'h00);
    answer(1'b1);
    chk(ack_v === 1'b1 && ack_a === ea && ack_s === es && irq === 1'b0, "ack answer");
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    end_of_test();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    logic [7:0]  v;
    logic [15:0] a;
    {failures, num_checks} = '0;
    {rst_in, init_sw, pwr_fail, strap_en, strap_addr, size} = {4'h8, 8'h00, 2'h0};
    dev_exp = 8'hae;
    void'($urandom(32'h37d8536f));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
    chk(dev_a === 8'hae && protect_on === 1'b0 && irq === 1'b0, "reset state");
    $display("reset test done");
    // Mask load with wrap; ninth byte lands in byte 0 and protects block 0
    for (int k = 0; k < 3; k++) begin
      cpu.io(1, dev_exp, 8'hff); // Sequencer left mid-mask
    end
    cmd(8'h00);
    for (int k = 0; k < 9; k++) begin
      v = $urandom;
      if (k == 8) v[7] = 1'b1;
      mask[k % 8] = v;
      cpu.io(1, dev_exp, v);
    end
    cmd(8'h60);
    chk(protect_on === 1'b1 && arm === 1'b1, "enable with arm");
    // Lookups at each block size, corners first
    for (int s = 0; s < 4; s++) begin // Strap code 3 acts as 512
      @(posedge clk_in);
      size <= s[1:0];
      repeat (3) @(posedge clk_in);
      for (int n = 0; n < 40; n++) begin
        a = (n == 0) ? 16'h0000 : (n == 1) ? 16'hffff : (n == 2) ? 16'h8000 : $urandom;
        cpu.mem(a, 1'b1, 1'b0);
        #1;
        chk(inh === exp_prot(a, s[1:0]), "block lookup");
      end
    end
    cpu.mem(16'h0000, 1'b0, 1'b0);
    #1;
    chk(irq === 1'b1, "armed fault interrupt");
    status_is(8'h34);
    ack_is(8'hae, 8'h20);
    status_is(8'h20);
    ack_is(8'h00, 8'h04);
    $display("mask and lookup test done");
    // Privileged write, then disarmed fault that must not be queued
    cpu.mem(16'h0000, 1'b1, 1'b1);
    #1;
    chk(inh === 1'b0, "privileged write");
    cpu.mem(16'h0000, 1'b1, 1'b0);
    cpu.mem(16'h0000, 1'b0, 1'b0);
    #1;
    chk(irq === 1'b1, "armed fault pending");
    cmd(8'h80);
    chk(irq === 1'b0 && arm === 1'b0, "disarm drops interrupt");
    cpu.mem(16'h0000, 1'b1, 1'b0);
    #1;
    chk(inh === 1'b1, "protected block");
    cpu.mem(16'h0000, 1'b0, 1'b0);
    repeat (2) @(posedge clk_in);
    #1;
    chk(irq === 1'b0, "disarmed fault");
    cmd(8'h40);
    chk(irq === 1'b0 && arm === 1'b1, "no queued interrupt");
    status_is(8'h20);
    cpu.io(0, ~dev_exp, 8'h10);
    #1;
    chk(protect_on === 1'b1, "foreign address");
    cmd(8'h30);
    chk(protect_on === 1'b0, "disable wins");
    cpu.mem(16'h0000, 1'b1, 1'b0);
    #1;
    chk(inh === 1'b0, "protection off");
    cpu.mem(16'h0000, 1'b0, 1'b0);
    $display("command test done");
    // Panel initialize and power-down clear
    for (int p = 0; p < 2; p++) begin
      cmd(8'h60);
      cpu.io(1, dev_exp, 8'h00); // Byte 0 clear, sequencer at byte 1
      @(posedge clk_in);
      {pwr_fail, init_sw} <= p[0] ? 2'b10 : 2'b01;
      repeat (4) @(posedge clk_in);
      {pwr_fail, init_sw} <= 2'b00;
      repeat (5) @(posedge clk_in);
      #1;
      chk(protect_on === 1'b0 && arm === 1'b0 && irq === 1'b0, "initialize clear");
      cpu.io(1, dev_exp, 8'h80);
      cmd(8'h20);
      cpu.mem(16'h0000, 1'b1, 1'b0);
      #1;
      chk(inh === 1'b1, "sequencer cleared by initialize");
      cpu.mem(16'h0000, 1'b0, 1'b0);
    end
    // Strapped device address
    @(posedge clk_in);
    {strap_en, strap_addr} <= {1'b1, 8'h3c};
    repeat (3) @(posedge clk_in);
    #1;
    chk(dev_a === 8'h3c, "strapped address");
    dev_exp = 8'h3c;
    cmd(8'h40);
    chk(arm === 1'b1, "command at strapped address");
    $display("initialize and strap test done");
    end_of_test();
  end
endmodule
